// ===== design/adc_out_cfg.sv
// Purpose: output test pattern, self test, trim and format registers
// Assumes: samples arrive on sys_clk; serial framing decoded elsewhere
// Notes: read data appears one clock after the address
`timescale 1ns/1ps
module adc_out_cfg #(
  parameter int SW = 14
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [1:0] reg_chan_mask,
  output logic [7:0] reg_rdata,
  // Converted samples
  input wire logic [SW-1:0] sample_a,
  input wire logic [SW-1:0] sample_b,
  // Output pins
  output logic [SW-1:0] data_out_a,
  output logic [SW-1:0] data_out_b,
  output logic data_out_en,
  output logic data_clock_output,
  output logic [1:0] data_stripes,
  output logic [1:0] dco_stripes,
  output logic [15:0] self_test_signature
);
  import adc_out_cfg_pkg::*;

  // ==========================================
  // Register file
  logic [7:0] test_pattern_control [2];
  logic [7:0] self_test_control;
  logic [7:0] offset_trim;
  logic [7:0] output_format_config;
  logic [7:0] output_drive_strength;
  wire wr_test = reg_wr && (reg_addr == ADDR_TEST_PATTERN);
  wire wr_self = reg_wr && (reg_addr == ADDR_SELF_TEST);
  wire [7:0] tp_rd = reg_chan_mask[0] ? test_pattern_control[0] : test_pattern_control[1];
  logic [7:0] next_rdata;

  always_comb begin
    if (reg_addr == ADDR_TEST_PATTERN) begin
      next_rdata = tp_rd;
    end else if (reg_addr == ADDR_SELF_TEST) begin
      next_rdata = self_test_control & MASK_SELF_TEST;
    end else if (reg_addr == ADDR_OFFSET_TRIM) begin
      next_rdata = offset_trim;
    end else if (reg_addr == ADDR_OUT_FORMAT) begin
      next_rdata = output_format_config & MASK_OUT_FORMAT;
    end else if (reg_addr == ADDR_DRIVE) begin
      next_rdata = output_drive_strength;
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      self_test_control <= RST_SELF_TEST;
      offset_trim <= RST_OFFSET_TRIM;
      output_format_config <= RST_OUT_FORMAT;
      output_drive_strength <= RST_DRIVE;
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
      if (wr_self) begin
        self_test_control <= reg_wdata;
      end else begin
        // Init is a one-shot; self clears after one cycle
        self_test_control[SELF_TEST_INIT_BIT] <= 1'b0;
      end
      if (reg_wr && reg_addr == ADDR_OFFSET_TRIM) begin
        offset_trim <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_OUT_FORMAT) begin
        output_format_config <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_DRIVE) begin
        output_drive_strength <= reg_wdata;
      end
    end
  end

  // ==========================================
  // Shared pattern sources
  logic phase;
  logic [SW-1:0] mix_cnt;
  logic [SW-1:0] walk_one;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase <= 1'b0;
      mix_cnt <= '0;
      walk_one <= SW'(1);
    end else begin
      phase <= ~phase;
      mix_cnt <= mix_cnt + SW'(1);
      walk_one <= {walk_one[SW-2:0], walk_one[SW-1]};
    end
  end

  wire fmt_invert = output_format_config[INVERT_BIT];
  wire [1:0] fmt_sel = output_format_config[FMT_LSB +: 2];
  wire [14:0] trim_ext = {{7{offset_trim[7]}}, offset_trim};
  wire [SW-1:0] samples [2];
  assign samples[0] = sample_a;
  assign samples[1] = sample_b;
  logic [SW-1:0] chan_word [2];

  // ==========================================
  // Per-channel datapath
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [22:0] pn_long;
      logic [8:0] pn_short;
      logic [SW-1:0] pat;
      logic [SW-1:0] fmt_word;
      wire [3:0] sel = test_pattern_control[ch][3:0];
      wire wr_me = wr_test && reg_chan_mask[ch];
      wire [14:0] sum = {1'b0, samples[ch]} + trim_ext;
      // Saturate the trimmed sample rather than wrap
      wire [SW-1:0] adj = sum[14] ? (offset_trim[7] ? '0 : '1) : sum[SW-1:0];
      wire [SW-1:0] gray = adj ^ (adj >> 1);

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          test_pattern_control[ch] <= RST_TEST_PATTERN;
          pn_long <= '1;
          pn_short <= '1;
        end else begin
          if (wr_me) begin
            test_pattern_control[ch] <= reg_wdata;
          end
          if (test_pattern_control[ch][PN_LONG_RST_BIT]) begin
            pn_long <= '1;
          end else begin
            pn_long <= {pn_long[21:0], pn_long[22] ^ pn_long[17]};
          end
          if (test_pattern_control[ch][PN_SHORT_RST_BIT]) begin
            pn_short <= '1;
          end else begin
            pn_short <= {pn_short[7:0], pn_short[8] ^ pn_short[4]};
          end
        end
      end

      always_comb begin
        case (fmt_sel)
          FMT_TWOS: fmt_word = {~adj[SW-1], adj[SW-2:0]};
          FMT_GRAY: fmt_word = gray;
          default: fmt_word = adj;
        endcase
      end

      always_comb begin
        case (test_code_t'(sel))
          TP_MID: pat = {1'b1, {(SW-1){1'b0}}};
          TP_POS_FS: pat = '1;
          TP_NEG_FS: pat = '0;
          TP_CHECKER: pat = phase ? {(SW/2){2'b01}} : {(SW/2){2'b10}};
          TP_PN_LONG: pat = pn_long[SW-1:0];
          TP_PN_SHORT: pat = {pn_short, pn_long[SW-10:0]};
          TP_WORD_TOG: pat = phase ? '0 : '1;
          TP_BIT_TOG: pat = {(SW/2){2'b10}};
          TP_SYNC: pat = {1'b0, {(SW-1){1'b1}}};
          TP_ONE_HIGH: pat = walk_one;
          TP_MIXED: pat = mix_cnt;
          TP_USER: pat = '0;
          default: pat = fmt_invert ? ~fmt_word : fmt_word;
        endcase
      end
      assign chan_word[ch] = pat;
    end
  endgenerate

  // ==========================================
  // Output pins and drive selection
  wire out_off = output_format_config[DISABLE_BIT];
  wire mux_on = output_format_config[MUX_BIT];
  wire sup_18 = output_format_config[VSUP_MSB];
  wire [SW-1:0] word_a = mux_on && phase ? chan_word[1] : chan_word[0];
  wire [1:0] next_data_str = sup_18 ? output_drive_strength[DATA18_LSB +: 2]
                                    : output_drive_strength[DATA33_LSB +: 2];
  wire [1:0] next_dco_str = sup_18 ? output_drive_strength[DCO18_LSB +: 2]
                                   : output_drive_strength[DCO33_LSB +: 2];
  wire [15:0] sig_fb = {self_test_signature[14:0],
                        self_test_signature[15] ^ self_test_signature[12]
                        ^ self_test_signature[3] ^ self_test_signature[0]};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_out_a <= '0;
      data_out_b <= '0;
      data_out_en <= 1'b0;
      data_clock_output <= 1'b0;
      data_stripes <= 2'h0;
      dco_stripes <= 2'h0;
      self_test_signature <= 16'h0000;
    end else begin
      data_out_a <= out_off ? '0 : word_a;
      data_out_b <= out_off ? '0 : chan_word[1];
      data_out_en <= ~out_off;
      data_clock_output <= phase;
      data_stripes <= next_data_str;
      dco_stripes <= next_dco_str;
      if (self_test_control[SELF_TEST_INIT_BIT]) begin
        self_test_signature <= 16'h0000;
      end else if (self_test_control[SELF_TEST_EN_BIT]) begin
        self_test_signature <= sig_fb ^ {2'h0, word_a};
      end
    end
  end
endmodule

// ===== design/adc_out_cfg_pkg.sv
// Purpose: constants for the converter output test and configuration registers
// Assumes: 8-bit register port, two channels, 14-bit samples
// Notes: offsets are register addresses on the serial control port
// Summary of operation
// - Per-channel four-bit test select replaces samples
// - Zero code passes converted data; reset zero
// - Checkerboard code alternates complementary bit patterns
// - Long code drives 23-stage pseudo-noise
// - Word toggle alternates all ones, all zeros
// - Bit toggle outputs alternating bits
// - Mixed code toggles bits at different rates
package adc_out_cfg_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] ADDR_TEST_PATTERN = 8'h0d;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0e;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h14;
  localparam logic [7:0] ADDR_DRIVE = 8'h15;
  // ==========================================
  // Reset values and read masks
  localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
  localparam logic [7:0] RST_SELF_TEST = 8'h00;
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RST_OUT_FORMAT = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h22;
  localparam logic [7:0] MASK_SELF_TEST = 8'h05;
  localparam logic [7:0] MASK_OUT_FORMAT = 8'hf7;
  // ==========================================
  // Field positions
  localparam int SELF_TEST_EN_BIT = 0;
  localparam int SELF_TEST_INIT_BIT = 2;
  localparam int PN_SHORT_RST_BIT = 4;
  localparam int PN_LONG_RST_BIT = 5;
  localparam int FMT_LSB = 0;
  localparam int INVERT_BIT = 2;
  localparam int DISABLE_BIT = 4;
  localparam int MUX_BIT = 5;
  localparam int VSUP_MSB = 7;
  localparam int DATA18_LSB = 0;
  localparam int DATA33_LSB = 2;
  localparam int DCO18_LSB = 4;
  localparam int DCO33_LSB = 6;
  // ==========================================
  // Test pattern codes
  typedef enum logic [3:0] {
    TP_OFF = 4'h0, TP_MID = 4'h1, TP_POS_FS = 4'h2, TP_NEG_FS = 4'h3,
    TP_CHECKER = 4'h4, TP_PN_LONG = 4'h5, TP_PN_SHORT = 4'h6, TP_WORD_TOG = 4'h7,
    TP_USER = 4'h8, TP_BIT_TOG = 4'h9, TP_SYNC = 4'ha, TP_ONE_HIGH = 4'hb,
    TP_MIXED = 4'hc
  } test_code_t;
  // Output formats
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam logic [1:0] FMT_GRAY = 2'h2;
endpackage

// ===== test/adc_out_cfg_assertions.sv
// Purpose: port checks for the output config block
// Assumes: rising edge of sys_clk
// Notes: register contents are not visible here
`timescale 1ns/1ps
module adc_out_cfg_assertions import adc_out_cfg_pkg::*; #(
  parameter int SW = 14
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // Outputs
  input wire logic [SW-1:0] data_out_a,
  input wire logic [SW-1:0] data_out_b,
  input wire logic data_out_en,
  input wire logic data_clock_output
);
  wire logic mapped = reg_addr inside {ADDR_TEST_PATTERN, ADDR_SELF_TEST,
    ADDR_OFFSET_TRIM, ADDR_OUT_FORMAT, ADDR_DRIVE};
  // ==========================================
  // Properties
  property p_rst_rd;
    @(posedge sys_clk) srst |=> reg_rdata == 8'h00;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("read data not cleared");
  property p_unmapped;
    @(posedge sys_clk) disable iff (srst) !mapped |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask_st;
    @(posedge sys_clk) disable iff (srst)
      reg_addr == ADDR_SELF_TEST |=> (reg_rdata & ~MASK_SELF_TEST) == 8'h00;
  endproperty
  a_mask_st: assert property (p_mask_st) else $error("self test open bits read");
  property p_mask_fmt;
    @(posedge sys_clk) disable iff (srst) reg_addr == ADDR_OUT_FORMAT |=> !reg_rdata[3];
  endproperty
  a_mask_fmt: assert property (p_mask_fmt) else $error("format open bit read");
  property p_drive_rst;
    @(posedge sys_clk) srst ##1 (!srst && !reg_wr && reg_addr == ADDR_DRIVE)
      |=> reg_rdata == RST_DRIVE;
  endproperty
  a_drive_rst: assert property (p_drive_rst) else $error("drive reset value");
  property p_en_rise;
    @(posedge sys_clk) $fell(srst) |=> data_out_en;
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("outputs not enabled");
  property p_dis_zero;
    @(posedge sys_clk) disable iff (srst) !data_out_en |-> data_out_a == '0 && data_out_b == '0;
  endproperty
  a_dis_zero: assert property (p_dis_zero) else $error("disabled outputs not zero");
  property p_dco_tog;
    @(posedge sys_clk) disable iff (srst)
      !$past(srst) && !$past(srst, 2) |-> data_clock_output != $past(data_clock_output);
  endproperty
  a_dco_tog: assert property (p_dco_tog) else $error("data clock not toggling");
endmodule
bind adc_out_cfg adc_out_cfg_assertions #(.SW(SW)) u_chk (.sys_clk, .srst, .reg_wr,
  .reg_addr, .reg_rdata, .data_out_a, .data_out_b, .data_out_en, .data_clock_output);

// ===== test/cfg_host.sv
// Purpose: host model on the register port
// Assumes: drives after the falling edge
// Notes: write data scrambled once released
`timescale 1ns/1ps
module cfg_host (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [1:0] reg_chan_mask,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h15;
    reg_wdata = 8'h5a;
    reg_chan_mask = 2'h1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] m);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_chan_mask = m;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_chan_mask = 2'h1;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// ===== test/tb.sv
// Purpose: register and pattern tests
// Assumes: fixed samples on both channels
// Notes: PN output only checked for seed and motion
`timescale 1ns/1ps
module tb;
  import adc_out_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [13:0] sample_a = 14'h1234;
  logic [13:0] sample_b = 14'h0abc;
  wire logic reg_wr;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic [1:0] reg_chan_mask, data_stripes, dco_stripes;
  wire logic [13:0] data_out_a, data_out_b;
  wire logic data_out_en, data_clock_output;
  wire logic [15:0] self_test_signature;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] r;
  logic [15:0] w0, w1;
  adc_out_cfg dut (.sys_clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_chan_mask,
    .reg_rdata, .sample_a, .sample_b, .data_out_a, .data_out_b, .data_out_en,
    .data_clock_output, .data_stripes, .dco_stripes, .self_test_signature);
  cfg_host host (.sys_clk, .reg_wr, .reg_addr, .reg_wdata, .reg_chan_mask, .reg_rdata);
  initial forever #50 sys_clk = ~sys_clk;
  // ==========================================
  // Helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] nrm(input logic [13:0] x, input logic [1:0] f);
    nrm = {2'h0, f == 2'h1 ? x ^ 14'h2000 : f == 2'h2 ? x ^ (x >> 1) : x};
  endfunction
  task automatic pat(input logic [7:0] v);
    host.wr(ADDR_TEST_PATTERN, v, 2'h1);
    repeat (4) @(negedge sys_clk);
    w0 = {2'h0, data_out_a};
    @(negedge sys_clk);
    w1 = {2'h0, data_out_a};
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    host.rd(ADDR_DRIVE, r);
    chk(16'(r), 16'(RST_DRIVE));
    host.rd(ADDR_TEST_PATTERN, r);
    chk(16'(r), 16'(RST_TEST_PATTERN));
    host.rd(8'h11, r);
    chk(16'(r), 16'h0);
    $display("reset values done");
    host.wr(ADDR_SELF_TEST, 8'h05, 2'h1);
    repeat (8) @(negedge sys_clk);
    chk(16'(self_test_signature != 16'h0), 16'h1);
    host.rd(ADDR_SELF_TEST, r);
    chk(16'(r), 16'h1);
    host.wr(ADDR_SELF_TEST, 8'h04, 2'h1);
    repeat (3) @(negedge sys_clk);
    chk(self_test_signature, 16'h0);
    $display("self test done");
    host.wr(ADDR_OUT_FORMAT, 8'hff, 2'h1);
    host.rd(ADDR_OUT_FORMAT, r);
    chk(16'(r), 16'h00f7);
    chk(16'(data_out_en), 16'h0);
    host.wr(ADDR_DRIVE, 8'he4, 2'h1);
    host.wr(ADDR_OUT_FORMAT, 8'h00, 2'h1);
    repeat (3) @(negedge sys_clk);
    chk({12'h0, data_stripes, dco_stripes}, 16'h7);
    for (int f = 0; f < 4; f++) begin
      host.wr(ADDR_OUT_FORMAT, 8'h80 | 8'(f), 2'h1);
      repeat (4) @(negedge sys_clk);
      chk(16'(data_out_a), nrm(sample_a, 2'(f)));
      chk({12'h0, data_stripes, dco_stripes}, 16'h2);
    end
    // Negative trim, then invert with channel interleave
    host.wr(ADDR_OFFSET_TRIM, 8'hf0, 2'h1);
    host.rd(ADDR_OFFSET_TRIM, r);
    chk(16'(r), 16'h00f0);
    chk(16'(data_out_a), nrm(sample_a - 14'h10, 2'h3));
    host.wr(ADDR_OFFSET_TRIM, 8'h00, 2'h1);
    host.wr(ADDR_OUT_FORMAT, 8'h24, 2'h1);
    repeat (3) @(negedge sys_clk);
    w0 = {2'h0, data_out_a};
    r[0] = data_clock_output;
    @(negedge sys_clk);
    w1 = {2'h0, data_out_a};
    chk(16'(data_clock_output ^ r[0]), 16'h1);
    chk(w0 ^ w1, {2'h0, sample_a ^ sample_b});
    chk(16'(w0 == {2'h0, ~sample_a} || w1 == {2'h0, ~sample_a}), 16'h1);
    chk(16'(data_out_b), {2'h0, ~sample_b});
    host.wr(ADDR_OUT_FORMAT, 8'h83, 2'h1);
    $display("format and drive done");
    pat(8'h25);
    chk(w0 & w1, 16'h3fff);
    pat(8'h05);
    chk(16'(w0 != w1), 16'h1);
    pat(8'h04);
    chk(w0 ^ w1, 16'h3fff);
    chk(16'(w0 == 16'h2aaa || w0 == 16'h1555), 16'h1);
    pat(8'h07);
    chk(w0 ^ w1, 16'h3fff);
    chk(16'(w0 == 16'h0 || w0 == 16'h3fff), 16'h1);
    pat(8'h09);
    chk(w0 | w1, 16'h2aaa);
    pat(8'h0c);
    chk(w1, {2'h0, w0[13:0] + 14'h1});
    chk(16'(data_out_b), nrm(sample_b, 2'h3));
    pat(8'h00);
    chk(w0, nrm(sample_a, 2'h3));
    // Channel B alone gets word toggle
    host.wr(ADDR_TEST_PATTERN, 8'h07, 2'h2);
    repeat (3) @(negedge sys_clk);
    w0 = {2'h0, data_out_b};
    @(negedge sys_clk);
    chk(w0 ^ {2'h0, data_out_b}, 16'h3fff);
    chk(16'(data_out_a), nrm(sample_a, 2'h3));
    $display("patterns done");
    complete_run();
  end
endmodule
